// file: hw/pulse_rate_regs.svh
// Purpose: register map, field layout and timing constants for the
//          pulse rate window counter
// Assumes: 32-bit APB, one aligned word per register
// Notes:   offsets are word indices; the byte address is four times each
`ifndef PULSE_RATE_REGS_SVH
`define PULSE_RATE_REGS_SVH

// settings block of one unit in host memory: base plus stride per unit
`define PRW_HOST_BASE_WORD   20000
`define PRW_HOST_UNIT_STRIDE 100

// per-input settings words, word index inside the unit's block
`define PRW_SETUP1_IDX 10'h01E
`define PRW_SETUP2_IDX 10'h026
`define PRW_SETUP3_IDX 10'h02E
`define PRW_SETUP4_IDX 10'h036

// read-only window counts, one per input
`define PRW_COUNT1_IDX 10'h040
`define PRW_COUNT2_IDX 10'h041
`define PRW_COUNT3_IDX 10'h042
`define PRW_COUNT4_IDX 10'h043

// settings word fields
`define PRW_DP_LSB     0
`define PRW_DP_MSB     3
`define PRW_PER_LSB    4
`define PRW_PER_MSB    7
`define PRW_SETUP_W    8
`define PRW_SETUP_RST  8'h00

// timing
`define PRW_SEC_NS       1000000000
`define PRW_CLK_NS       100
`define PRW_TICKS_PER_S  (`PRW_SEC_NS / `PRW_CLK_NS)

// window lengths in seconds per period code
`define PRW_PERIOD0_S 1
`define PRW_PERIOD1_S 3
`define PRW_PERIOD2_S 10
`define PRW_PERIOD3_S 30
`define PRW_PERIOD4_S 60

`endif

// file: hw/pulse_rate_pkg.sv
// Purpose: shared types of the pulse rate window counter
// Assumes: constants live in pulse_rate_regs.svh
// Notes:   period codes follow the settings word encoding 0..4
package pulse_rate_pkg;
   typedef enum logic [3:0] {
      period_1s,
      period_3s,
      period_10s,
      period_30s,
      period_60s
   } period_code_t;
   typedef logic [7:0] setup_t;
endpackage

// file: hw/pulse_window_channel.sv
// Purpose: one input's measurement window and pulse counter
// Assumes: sec_tick is a one-cycle pulse once per second
// Notes:   a period change takes effect at the next second boundary
`timescale 1ns/1ns
`include "pulse_rate_regs.svh"
module pulse_window_channel #(
   parameter int CNT_W = 32
) (
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   // timing and pulses
   input  wire logic                          sec_tick,
   input  wire logic                          pulse_edge,
   input  wire pulse_rate_pkg::period_code_t  period_code,
   // result
   output logic [CNT_W-1:0]                   count_out,
   output logic                               window_done
);
   import pulse_rate_pkg::*;

   logic [5:0]       period_s;
   logic [5:0]       sec_cnt_reg;
   logic [5:0]       sec_cnt_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic [CNT_W-1:0] edge_inc;
   wire              win_end;

   // unknown codes fall back to the one second window
   always_comb begin
      case (period_code)
         period_1s:  period_s = 6'(`PRW_PERIOD0_S); // RQ2
         period_3s:  period_s = 6'(`PRW_PERIOD1_S);
         period_10s: period_s = 6'(`PRW_PERIOD2_S);
         period_30s: period_s = 6'(`PRW_PERIOD3_S);
         period_60s: period_s = 6'(`PRW_PERIOD4_S);
         default:    period_s = 6'(`PRW_PERIOD0_S); // RQ4
      endcase
   end

   // >= so that shortening the period mid-window to sec_cnt_reg or below ends it at the next sec_tick
   assign win_end      = sec_tick && (sec_cnt_reg >= period_s - 6'h1); // RQ6
   assign sec_cnt_next = win_end ? 6'h0 :
                         (sec_tick ? sec_cnt_reg + 6'h1 : sec_cnt_reg);
   assign edge_inc     = {{(CNT_W-1){1'b0}}, pulse_edge};
   // a boundary edge is kept by the closing window, new one starts at 0
   assign cnt_next     = win_end ? {CNT_W{1'b0}} : cnt_reg + edge_inc; // RQ6

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sec_cnt_reg <= 6'h0;
         cnt_reg     <= '0;
         count_out   <= '0;
         window_done <= 1'b0;
      end else begin
         sec_cnt_reg <= sec_cnt_next;
         cnt_reg     <= cnt_next;
         window_done <= win_end;
         if (win_end) begin
            count_out <= cnt_reg + edge_inc; // RQ1
         end
      end
   end

   sequence s_close;
      win_end ##0 pulse_edge;
   endsequence

   property p_latch;
      @(posedge clk) disable iff (!rst_n)
      win_end |=> count_out == $past(cnt_reg) + $past(edge_inc);
   endproperty
   a_latch: assert property (p_latch) // RQ1
      else $error("window count not latched with boundary edge");

   property p_restart;
      @(posedge clk) disable iff (!rst_n)
      win_end |=> cnt_reg == '0 && sec_cnt_reg == 6'h0;
   endproperty
   a_restart: assert property (p_restart) // RQ6
      else $error("window did not restart from zero");

   property p_boundary_edge;
      @(posedge clk) disable iff (!rst_n)
      s_close |=> window_done && count_out != '0;
   endproperty
   a_boundary_edge: assert property (p_boundary_edge) // RQ6
      else $error("edge on window boundary lost");

   property p_length;
      @(posedge clk) disable iff (!rst_n)
      win_end && $stable(period_code) && $past(sec_cnt_reg) < period_s
         |-> sec_cnt_reg == period_s - 6'h1;
   endproperty
   a_length: assert property (p_length) // RQ2
      else $error("window closed at wrong second");
endmodule

// file: hw/pulse_rate_window_counter.sv
// Purpose: four-input pulse rate counter with per-input measurement window
// Assumes: 10 MHz ref_clk, APB master on the same clock
// Notes:   counts are raw pulses per window, no scaling applied here
//
// Contract
// [RQ1] count pulses over one whole window, report the raw count
// [RQ2] settings bits 7:4 pick window 1, 3, 10, 30 or 60 seconds
// [RQ3] settings bits 3:0 hold decimal point position 0 to 3
// [RQ4] period code left at reset value gives a one second window
// [RQ5] settings words sit at unit block offsets 30, 38, 46 and 54
// [RQ6] windows timed from own clock, boundary edges never lost
`timescale 1ns/1ns
`include "pulse_rate_regs.svh"
module pulse_rate_window_counter #(
   parameter int CNT_W       = 32,
   parameter int TICKS_PER_S = `PRW_TICKS_PER_S
) (
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              arst_n,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // pulse inputs from the field
   input  wire logic [3:0]        pulse_in,
   // per-input window results and decimal point positions
   output logic [3:0]             window_done,
   output logic [4*CNT_W-1:0]     count_flat,
   output logic [15:0]            dp_pos_flat
);
   import pulse_rate_pkg::*;

   localparam logic [9:0] SETUP_IDX [4] = '{
      `PRW_SETUP1_IDX, `PRW_SETUP2_IDX, `PRW_SETUP3_IDX, `PRW_SETUP4_IDX};
   localparam logic [9:0] COUNT_IDX [4] = '{
      `PRW_COUNT1_IDX, `PRW_COUNT2_IDX, `PRW_COUNT3_IDX, `PRW_COUNT4_IDX};
   localparam logic [31:0] TICK_LAST = 32'(TICKS_PER_S - 1);

   // reset release
   logic        rst_s1_reg;
   logic        rst_n;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_reg <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n      <= rst_s1_reg;
      end
   end

   // pulse synchronisers and rising edge detect
   logic [3:0]  pin_s1_reg;
   logic [3:0]  pin_s2_reg;
   logic [3:0]  pin_prev_reg;
   wire  [3:0]  pulse_edge;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_reg   <= 4'h0;
         pin_s2_reg   <= 4'h0;
         pin_prev_reg <= 4'h0;
      end else begin
         pin_s1_reg   <= pulse_in;
         pin_s2_reg   <= pin_s1_reg;
         pin_prev_reg <= pin_s2_reg;
      end
   end

   assign pulse_edge = pin_s2_reg & ~pin_prev_reg;

   // one second enable shared by all inputs; a free-running divider
   // means a new setting waits at most a second to take effect
   logic [31:0] tick_cnt_reg;
   logic [31:0] tick_cnt_next;
   wire         sec_tick;

   assign sec_tick      = (tick_cnt_reg == TICK_LAST); // RQ6
   assign tick_cnt_next = sec_tick ? 32'h0 : tick_cnt_reg + 32'h1;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_reg <= 32'h0;
      end else begin
         tick_cnt_reg <= tick_cnt_next;
      end
   end

   // settings words
   setup_t      setup_reg [4];
   logic [3:0]  setup_hit;
   logic [3:0]  count_hit;
   wire  [9:0]  widx;
   wire         setup_phase;
   wire         wr_access;
   wire         mapped;

   assign widx        = paddr[11:2];
   assign setup_phase = psel && !penable;
   assign wr_access   = psel && penable && pwrite && pstrb[0];
   assign mapped      = |{setup_hit, count_hit};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_ch
         assign setup_hit[gi] = (widx == SETUP_IDX[gi]); // RQ5
         assign count_hit[gi] = (widx == COUNT_IDX[gi]);
         assign dp_pos_flat[gi*4 +: 4] =
            setup_reg[gi][`PRW_DP_MSB:`PRW_DP_LSB]; // RQ3

         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               setup_reg[gi] <= `PRW_SETUP_RST; // RQ4
            end else if (wr_access && setup_hit[gi]) begin
               setup_reg[gi] <= pwdata[7:0]; // RQ2
            end
         end

         pulse_window_channel #(
            .CNT_W (CNT_W)
         ) u_chan (
            .clk         (ref_clk),
            .rst_n       (rst_n),
            .sec_tick    (sec_tick),
            .pulse_edge  (pulse_edge[gi]),
            .period_code (period_code_t'(
                            setup_reg[gi][`PRW_PER_MSB:`PRW_PER_LSB])),
            .count_out   (count_flat[gi*CNT_W +: CNT_W]),
            .window_done (window_done[gi])
         );
      end
   endgenerate

   // read mux, captured in the setup phase so prdata comes from a flop
   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = 32'h0;
      for (int i = 0; i < 4; i++) begin
         if (setup_hit[i]) begin
            rd_mux = {24'h0, setup_reg[i]};
         end
         if (count_hit[i]) begin
            rd_mux = 32'(count_flat[i*CNT_W +: CNT_W]);
         end
      end
   end

   logic        err_reg;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h0;
         err_reg <= 1'b0;
      end else if (setup_phase) begin
         prdata  <= pwrite ? 32'h0 : rd_mux;
         err_reg <= !mapped || (pwrite && |count_hit);
      end
   end

   // one wait-free access phase; errors only show with pready
   assign pready  = penable;
   assign pslverr = psel && penable && err_reg;

   property p_setup_write;
      @(posedge ref_clk) disable iff (!rst_n)
      wr_access && setup_hit[0] |=> setup_reg[0] == $past(pwdata[7:0]);
   endproperty
   a_setup_write: assert property (p_setup_write) // RQ2
      else $error("settings word 1 not written");

   property p_reset_period;
      @(posedge ref_clk)
      $rose(rst_n) |-> setup_reg[1] == `PRW_SETUP_RST;
   endproperty
   a_reset_period: assert property (p_reset_period) // RQ4
      else $error("settings not at one second after reset");

   sequence s_read_setup3;
      setup_phase && !pwrite && widx == `PRW_SETUP3_IDX;
   endsequence

   property p_map_read;
      @(posedge ref_clk) disable iff (!rst_n)
      s_read_setup3 |=> prdata == {24'h0, $past(setup_reg[2])} && !pslverr;
   endproperty
   a_map_read: assert property (p_map_read) // RQ5
      else $error("settings word 3 not at its offset");

   property p_dp_out;
      @(posedge ref_clk) disable iff (!rst_n)
      wr_access && setup_hit[3]
         |=> dp_pos_flat[15:12] == $past(pwdata[3:0]);
   endproperty
   a_dp_out: assert property (p_dp_out) // RQ3
      else $error("decimal point field not taken");

   property p_tick_rate;
      @(posedge ref_clk) disable iff (!rst_n)
      sec_tick |=> !sec_tick && tick_cnt_reg == 32'h0;
   endproperty
   a_tick_rate: assert property (p_tick_rate) // RQ6
      else $error("second divider not restarting");

   // the read takes the count standing at the setup edge, even when a
   // window closes on that same edge
   property p_count_read;
      @(posedge ref_clk) disable iff (!rst_n)
      setup_phase && !pwrite && widx == `PRW_COUNT1_IDX
         |=> prdata == 32'($past(count_flat[CNT_W-1:0]));
   endproperty
   a_count_read: assert property (p_count_read) // RQ1
      else $error("window count 1 read back wrong");
endmodule

// file: dv/pulse_source_model.sv
// Purpose: field pulse source for the four counter inputs
// Assumes: one request loads a burst length for one input
// Notes:   fast bursts are 2 high 2 low, slow ones 2 high 6 low
`timescale 1ns/1ns
module pulse_source_model (
   // clock
   input  wire logic       clk,
   // burst requests
   input  wire logic [3:0] go,
   input  wire logic [7:0] n_pulses,
   input  wire logic       slow,
   // field lines, idle low
   output logic [3:0]      pulse_out
);
   logic [7:0] left_reg [4];
   logic [2:0] ph_reg   [4];
   initial begin
      pulse_out = 4'h0;
      for (int i = 0; i < 4; i++) begin
         left_reg[i] = 8'h00;
         ph_reg[i]   = 3'h0;
      end
   end
   always @(posedge clk) begin
      for (int i = 0; i < 4; i++) begin
         if (go[i]) begin
            left_reg[i] <= n_pulses;
            ph_reg[i]   <= 3'h0;
         end else if (left_reg[i] != 8'h00) begin
            pulse_out[i] <= (ph_reg[i] < 3'h2);
            ph_reg[i]    <= ph_reg[i] + 3'h1;
            if (ph_reg[i] == (slow ? 3'h7 : 3'h3)) begin
               left_reg[i] <= left_reg[i] - 8'h01;
               ph_reg[i]   <= 3'h0;
            end
         end else begin
            pulse_out[i] <= 1'b0;
         end
      end
   end
endmodule

// file: dv/pulse_rate_window_counter_tb_top.sv
// Purpose: self-checking bench of the pulse rate window counter
// Assumes: one second shortened to 200 clocks
// Notes:   period change is measured on the second window after a write
`timescale 1ns/1ns
`include "pulse_rate_regs.svh"
module pulse_rate_window_counter_tb_top;
   localparam int TPS = 200;
   logic        ref_clk, arst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb, pulse_in, window_done, go;
   logic [127:0] count_flat;
   logic [15:0] dp_pos_flat;
   logic [7:0]  n_pulses;
   logic        slow;
   int          n_errors = 0;
   int          checks = 0;

   pulse_rate_window_counter #(.TICKS_PER_S(TPS)) dut (
      .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pulse_in(pulse_in), .window_done(window_done),
      .count_flat(count_flat), .dp_pos_flat(dp_pos_flat));
   pulse_source_model src (.clk(ref_clk), .go(go), .n_pulses(n_pulses),
      .slow(slow), .pulse_out(pulse_in));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one edge first so a release never meets a new setup in one step
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] rd, output logic er);
      int k;
      @(posedge ref_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
      paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge ref_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         n_errors++;
         give_verdict();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_done(input int ch, output int cyc);
      cyc = 0;
      do begin
         @(posedge ref_clk);
         cyc++;
      end while (window_done[ch] !== 1'b1 && cyc < 13000);
      if (cyc >= 13000) begin
         n_errors++;
         give_verdict();
      end
   endtask

   function automatic logic [11:0] sa(input int i);
      logic [9:0] t [4];
      t = '{`PRW_SETUP1_IDX, `PRW_SETUP2_IDX, `PRW_SETUP3_IDX,
            `PRW_SETUP4_IDX};
      return {t[i], 2'b00};
   endfunction

   function automatic int win_cycles(input int code);
      case (code)
         1: return `PRW_PERIOD1_S * TPS;
         2: return `PRW_PERIOD2_S * TPS;
         3: return `PRW_PERIOD3_S * TPS;
         4: return `PRW_PERIOD4_S * TPS;
         default: return `PRW_PERIOD0_S * TPS;
      endcase
   endfunction

   initial begin
      logic [31:0] rd, wd;
      logic        er;
      logic [3:0]  cd, dp;
      int          cyc, c2, n;
      arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hF;
      go = 4'h0; n_pulses = 8'h00; slow = 1'b0;
      void'($urandom(22947));
      repeat (10) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, sa(i), 32'h0, 4'hF, rd, er);
         chk("setup reset", rd, 32'h0);
      end
      wait_done(0, cyc);
      wait_done(0, cyc);
      chk("default window", 32'(cyc), 32'(TPS));
      for (int i = 0; i < 4; i++) begin
         cd = 4'($urandom % 5);
         dp = 4'($urandom % 4);
         wd = ($urandom & 32'hFFFF_FF00) | {24'h0, cd, dp};
         apb(1'b1, sa(i), wd, 4'hF, rd, er);
         apb(1'b1, sa(i), ~wd, 4'h0, rd, er);
         apb(1'b0, sa(i), 32'h0, 4'hF, rd, er);
         chk("setup readback", rd, {24'h0, cd, dp});
         chk("setup error", 32'(er), 32'h0);
         chk("dp field", 32'(dp_pos_flat[i*4 +: 4]), 32'(dp));
      end
      apb(1'b0, 12'h004, 32'h0, 4'hF, rd, er);
      chk("unmapped error", 32'(er), 32'h1);
      chk("unmapped data", rd, 32'h0);
      for (int c = 0; c < 6; c++) begin
         // codes 5 and above are undefined and must act as one second
         cd = (c < 5) ? 4'(c) : 4'(5 + $urandom % 11);
         apb(1'b1, sa(c % 4), {24'h0, cd, 4'h0}, 4'hF, rd, er);
         wait_done(c % 4, cyc);
         wait_done(c % 4, cyc);
         chk("window length", 32'(cyc), 32'(win_cycles(c)));
      end
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, sa(i), 32'h0, 4'hF, rd, er);
         for (int r = 0; r < 3; r++) begin
            n = (r == 0) ? 0 : 1 + $urandom % 20;
            wait_done(i, cyc);
            go[i] <= 1'b1; n_pulses <= 8'(n); slow <= r[0];
            @(posedge ref_clk);
            go <= 4'h0;
            wait_done(i, cyc);
            chk("window count", count_flat[i*32 +: 32], 32'(n));
            apb(1'b0, {`PRW_COUNT1_IDX + 10'(i), 2'b00}, 32'h0, 4'hF, rd, er);
            chk("count register", rd, 32'(n));
         end
      end
      apb(1'b1, {`PRW_COUNT1_IDX, 2'b00}, 32'h5, 4'hF, rd, er);
      chk("count write error", 32'(er), 32'h1);
      // a burst straddling a boundary must split without loss; go is
      // timed so that edge 24 of 60 falls in the closing cycle
      wait_done(0, cyc);
      repeat (102) @(posedge ref_clk);
      go[0] <= 1'b1; n_pulses <= 8'd60; slow <= 1'b0;
      @(posedge ref_clk);
      go <= 4'h0;
      wait_done(0, cyc);
      n = int'(count_flat[31:0]);
      wait_done(0, cyc);
      c2 = int'(count_flat[31:0]);
      chk("boundary window", 32'(n), 32'd24);
      chk("split burst", 32'(n + c2), 32'd60);
      give_verdict();
   end
endmodule
